/* nbl_cycle.v */
// one strobed bus cycle on the flash pins: command, address, or data read
`timescale 1ns/100ps
module nbl_cycle #(
  parameter HOLD = 3
) (
  input wire clk,
  input wire rst,
  input wire start,
  input wire [1:0] kind,
  input wire [7:0] byte_in,
  input wire [7:0] io_in,
  output reg cle_q,
  output reg ale_q,
  output reg we_n_q,
  output reg re_n_q,
  output reg [7:0] io_out_q,
  output reg io_oe_q,
  output reg [7:0] rd_q,
  output wire done
);
  reg [7:0] cnt_q;
  reg act_q;
  // kind: 0 command, 1 address, 2 read; strobe low for HOLD cycles then high for HOLD
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      act_q <= 1'b0;
      cle_q <= 1'b0;
      ale_q <= 1'b0;
      we_n_q <= 1'b1;
      re_n_q <= 1'b1;
      io_out_q <= 8'h00;
      io_oe_q <= 1'b0;
      rd_q <= 8'h00;
    end else if (start && !act_q) begin
      act_q <= 1'b1;
      cnt_q <= 8'h00;
      cle_q <= (kind == 2'd0);
      ale_q <= (kind == 2'd1);
      io_out_q <= byte_in;
      io_oe_q <= (kind != 2'd2);
      we_n_q <= (kind == 2'd2);
      re_n_q <= (kind != 2'd2);
    end else if (act_q) begin
      cnt_q <= cnt_q + 8'h01;
      if (cnt_q == HOLD - 1) begin
        // sample read data just before the strobe rises
        if (!re_n_q) rd_q <= io_in;
        we_n_q <= 1'b1;
        re_n_q <= 1'b1;
      end
      if (cnt_q == 2 * HOLD - 1) begin
        act_q <= 1'b0;
        cle_q <= 1'b0;
        ale_q <= 1'b0;
        io_oe_q <= 1'b0;
      end
    end
  end
  assign done = act_q && (cnt_q == 2 * HOLD - 1);
endmodule // nbl_cycle

/* nbl_flash_model.sv */
// behavioural flash device with per-block lock states, sixteen blocks
`timescale 1ns/100ps
module nbl_flash_model #(
  parameter LBSY_NS = 1000
) (
  input wire cle,
  input wire ale,
  input wire we_n,
  input wire re_n,
  input wire ce_n,
  input wire wp_n,
  input wire [7:0] io_out,
  input wire lfs,
  input wire hold_busy,
  output wire [7:0] io_in,
  output wire rb_n
);
  reg [1:0] st [0:15];
  reg [7:0] cmd = 8'h00;
  reg [7:0] last = 8'h00;
  reg [3:0] a_lo = 4'h0;
  reg [3:0] s_blk = 4'h0;
  integer acnt = 0;
  integer i;
  integer j;
  reg lbsy = 1'b0;
  // power-up: every block locked and no command latched, so a read with the strobe low returns C0h
  initial for (j = 0; j < 16; j = j + 1) st[j] = 2'h1;
  wire [2:0] code = (st[a_lo] == 2'h0) ? 3'h6 : (st[a_lo] == 2'h1) ? 3'h2 : 3'h1;
  // status follows the state live, so no strobe toggle is needed; upper bits are junk
  wire [7:0] dout = (cmd == 8'h7A) ? {5'h15, code} : 8'hC0;
  assign io_in = (!re_n && !ce_n) ? dout : ~last;
  assign rb_n = !hold_busy && !lbsy;
  // a refused erase shows busy for a short fixed time and then releases
  always @(posedge lbsy) #(LBSY_NS) lbsy = 1'b0;
  always @(posedge re_n) last = dout;
  // power-up and any write protect low pulse lock every block
  always @(negedge wp_n) for (i = 0; i < 16; i = i + 1) st[i] = 2'h1;
  // commands latch on the write strobe rising edge even with the feature pin low;
  // only the lock handling needs the pin high, so 70h still selects plain status
  always @(posedge we_n) if (!ce_n) begin
    if (cle) begin
      // erase confirm on a protected block: short busy only, array left alone
      if (lfs && io_out == 8'hD0 && cmd == 8'h60 && st[a_lo] != 2'h0) lbsy = 1'b1;
      cmd = io_out;
      acnt = 0;
      if (lfs) for (i = 0; i < 16; i = i + 1) begin
        if (io_out == 8'h2A && st[i] == 2'h0) st[i] = 2'h1;
        if (io_out == 8'h2C && st[i] == 2'h1) st[i] = 2'h2;
      end
    end else if (ale && lfs) begin
      if (acnt == 0) a_lo = io_out[3:0];
      acnt = acnt + 1;
      if (acnt == 2 && cmd == 8'h23) s_blk = a_lo;
      if (acnt == 2 && cmd == 8'h24) for (i = 0; i < 16; i = i + 1)
        if (st[i] != 2'h2) st[i] = (i >= s_blk && i <= a_lo) ? 2'h0 : 2'h1;
    end
  end
endmodule // nbl_flash_model

/* nbl_host.v */
// host controller that drives the flash block lock commands and reads lock status
//
// Overview of operation
// - lock command 2Ah locks every block at once; no per-block lock.
// - unlock is 23h, start block, 24h, end block; device unlocks that range.
// - host must send a start block not above the end block.
// - lock-tight command 2Ch moves locked blocks to lock-tight.
// - after 7Ah and a block address, each read returns that block's lock status.
// - host must not read lock status while the device is busy.
// - feature pin high uses 7Ah for protection status, low uses 70h.
// - host waits recovery time after power-up; write-protect low meanwhile.
`timescale 1ns/100ps
`include "nbl_map.vh"
module nbl_host #(
  parameter ADDR_CYCLES = 2,
  parameter RECOVERY_CYC = `NBL_RECOVERY_CYC
) (
  input wire clk,
  input wire rst,
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata_q,
  output wire flash_cle,
  output wire flash_ale,
  output wire flash_we_n,
  output wire output_strobe_n,
  output wire flash_ce_n,
  output reg flash_wp_n_q,
  output wire [7:0] flash_io_out,
  output wire flash_io_oe,
  input wire [7:0] flash_io_in,
  input wire flash_rb_n,
  input wire lock_feature_select
);
  localparam S_RECOV = 4'd0;
  localparam S_IDLE = 4'd1;
  localparam S_CMD = 4'd2;
  localparam S_ADR = 4'd3;
  localparam S_CMD2 = 4'd4;
  localparam S_ADR2 = 4'd5;
  localparam S_READ = 4'd6;
  localparam S_WP = 4'd7;
  localparam S_WAIT = 4'd8;

  reg [3:0] st_q;
  reg [15:0] tmr_q;
  reg [2:0] op_q;
  reg [15:0] start_q;
  reg [15:0] end_q;
  reg [7:0] result_q;
  reg err_q;
  reg [1:0] acnt_q;
  reg cyc_go;
  reg [1:0] cyc_kind;
  reg [7:0] cyc_byte;
  wire cyc_done;
  wire [7:0] cyc_rd;
  reg [7:0] io_s1_q, io_s2_q;
  reg rb_s1_q, rb_s2_q, lfs_s1_q, lfs_s2_q;

  // pin inputs pass two flops before anything reads them
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      io_s1_q <= 8'h00;
      io_s2_q <= 8'h00;
      rb_s1_q <= 1'b0;
      rb_s2_q <= 1'b0;
      lfs_s1_q <= 1'b0;
      lfs_s2_q <= 1'b0;
    end else begin
      io_s1_q <= flash_io_in;
      io_s2_q <= io_s1_q;
      rb_s1_q <= flash_rb_n;
      rb_s2_q <= rb_s1_q;
      lfs_s1_q <= lock_feature_select;
      lfs_s2_q <= lfs_s1_q;
    end
  end

  assign flash_ce_n = (st_q == S_RECOV);

  nbl_cycle #(.HOLD(`NBL_SETUP_CYC)) u_cyc (
    .clk(clk),
    .rst(rst),
    .start(cyc_go),
    .kind(cyc_kind),
    .byte_in(cyc_byte),
    .io_in(io_s2_q),
    .cle_q(flash_cle),
    .ale_q(flash_ale),
    .we_n_q(flash_we_n),
    .re_n_q(output_strobe_n),
    .io_out_q(flash_io_out),
    .io_oe_q(flash_io_oe),
    .rd_q(cyc_rd),
    .done(cyc_done)
  );

  // pick the pin cycle each state asks for
  always @* begin
    cyc_go = 1'b0;
    cyc_kind = 2'd0;
    cyc_byte = 8'h00;
    case (st_q)
      S_CMD: begin
        cyc_go = 1'b1;
        case (op_q)
          `NBL_OP_LOCK: cyc_byte = `NBL_CMD_LOCK;
          `NBL_OP_UNLOCK: cyc_byte = `NBL_CMD_UNLOCK_START;
          `NBL_OP_TIGHT: cyc_byte = `NBL_CMD_LOCK_TIGHT;
          // feature pin picks the status command
          default: cyc_byte = lfs_s2_q ? `NBL_CMD_LOCK_STATUS : `NBL_CMD_STATUS;
        endcase
      end
      S_ADR: begin
        cyc_go = 1'b1;
        cyc_kind = 2'd1;
        cyc_byte = (acnt_q == 2'd0) ? start_q[7:0] : start_q[15:8];
      end
      S_CMD2: begin
        cyc_go = 1'b1;
        cyc_byte = `NBL_CMD_UNLOCK_END;
      end
      S_ADR2: begin
        cyc_go = 1'b1;
        cyc_kind = 2'd1;
        cyc_byte = (acnt_q == 2'd0) ? end_q[7:0] : end_q[15:8];
      end
      S_READ: begin
        cyc_go = 1'b1;
        cyc_kind = 2'd2;
      end
      default: cyc_go = 1'b0;
    endcase
  end

  wire last_adr = (acnt_q == ADDR_CYCLES - 1);
  wire go = wr && (addr == `NBL_REG_CTRL) && wdata[`NBL_CTRL_GO_BIT] && (st_q == S_IDLE);

  // sequencer: one command sequence at a time
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= S_RECOV;
      tmr_q <= 16'h0000;
      op_q <= 3'h0;
      start_q <= 16'h0000;
      end_q <= 16'h0000;
      result_q <= 8'h00;
      err_q <= 1'b0;
      acnt_q <= 2'd0;
      flash_wp_n_q <= 1'b0;
    end else begin
      if (wr && addr == `NBL_REG_START && st_q == S_IDLE) start_q <= wdata;
      if (wr && addr == `NBL_REG_END && st_q == S_IDLE) end_q <= wdata;
      case (st_q)
        S_RECOV: begin
          // write-protect held low until the recovery time has passed
          tmr_q <= tmr_q + 16'h0001;
          if (tmr_q == RECOVERY_CYC - 1) begin
            st_q <= S_IDLE;
            flash_wp_n_q <= 1'b1;
          end
        end
        S_IDLE: begin
          acnt_q <= 2'd0;
          tmr_q <= 16'h0000;
          if (go) begin
            op_q <= wdata[2:0];
            err_q <= 1'b0;
            if (wdata[2:0] == `NBL_OP_WP_PULSE) begin
              st_q <= S_WP;
              flash_wp_n_q <= 1'b0;
            end else if (wdata[2:0] == `NBL_OP_UNLOCK && start_q > end_q) begin
              err_q <= 1'b1;
            end else if (wdata[2:0] == `NBL_OP_QUERY && !rb_s2_q) begin
              err_q <= 1'b1;
            end else if (wdata[2:0] > `NBL_OP_WP_PULSE) begin
              err_q <= 1'b1;
            end else begin
              st_q <= S_CMD;
            end
          end
        end
        S_CMD: if (cyc_done) begin
          if (op_q == `NBL_OP_UNLOCK) st_q <= S_ADR;
          else if (op_q == `NBL_OP_QUERY && lfs_s2_q) st_q <= S_ADR;
          else if (op_q == `NBL_OP_QUERY) st_q <= S_READ;
          else st_q <= S_WAIT;
        end
        S_ADR: if (cyc_done) begin
          acnt_q <= last_adr ? 2'd0 : acnt_q + 2'd1;
          if (last_adr) st_q <= (op_q == `NBL_OP_UNLOCK) ? S_CMD2 : S_READ;
        end
        S_CMD2: if (cyc_done) st_q <= S_ADR2;
        S_ADR2: if (cyc_done) begin
          acnt_q <= last_adr ? 2'd0 : acnt_q + 2'd1;
          if (last_adr) st_q <= S_WAIT;
        end
        S_READ: if (cyc_done) begin
          result_q <= cyc_rd;
          st_q <= S_IDLE;
        end
        S_WP: begin
          // low pulse on write-protect returns every block to locked
          tmr_q <= tmr_q + 16'h0001;
          if (tmr_q == `NBL_WP_PULSE_CYC - 1) begin
            flash_wp_n_q <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        S_WAIT: begin
          // let the ready/busy input settle through the synchroniser
          tmr_q <= tmr_q + 16'h0001;
          if (tmr_q >= 16'h0004 && rb_s2_q) st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // register reads, data one cycle after the strobe
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `NBL_REG_START: rdata_q <= start_q;
        `NBL_REG_END: rdata_q <= end_q;
        `NBL_REG_STATUS: rdata_q <= {11'h000, rb_s2_q, lfs_s2_q, err_q,
                                    st_q == S_IDLE, st_q != S_IDLE};
        `NBL_REG_RESULT: rdata_q <= {8'h00, result_q};
        default: rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end
endmodule // nbl_host

/* nbl_host_properties.sv */
// concurrent checks on the flash pins of the block lock host
`timescale 1ns/100ps
module nbl_host_properties (
  input wire clk,
  input wire rst,
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  input wire [15:0] rdata_q,
  input wire flash_cle,
  input wire flash_ale,
  input wire flash_we_n,
  input wire output_strobe_n,
  input wire flash_ce_n,
  input wire flash_wp_n_q,
  input wire [7:0] flash_io_out,
  input wire flash_io_oe,
  input wire [7:0] flash_io_in,
  input wire flash_rb_n,
  input wire lock_feature_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  recov_quiet_a:
    assert property (flash_ce_n |-> !flash_wp_n_q && flash_we_n && output_strobe_n)
    else $error("pins active during recovery");
  we_width_a:
    assert property ($fell(flash_we_n) |-> !flash_we_n [*3] ##1 flash_we_n [*3])
    else $error("write strobe width wrong");
  re_width_a:
    assert property ($fell(output_strobe_n) |-> !output_strobe_n [*3] ##1 output_strobe_n)
    else $error("read strobe width wrong");
  read_release_a:
    assert property (!output_strobe_n |-> !flash_io_oe && flash_we_n)
    else $error("host drives bus while reading");
  io_hold_a:
    assert property (!flash_we_n && !$past(flash_we_n) |-> flash_io_oe && $stable(flash_io_out))
    else $error("data moved under write strobe");
  latch_excl_a:
    assert property (flash_cle |-> !flash_ale)
    else $error("command and address latch both high");
  query_ready_a:
    assert property ($fell(flash_we_n) && flash_cle && flash_io_out == 8'h7A |-> flash_rb_n)
    else $error("lock status query while busy");
  cmd_feature_a:
    assert property ($fell(flash_we_n) && flash_cle |->
      (flash_io_out != 8'h7A || lock_feature_select) &&
      (flash_io_out != 8'h70 || !lock_feature_select))
    else $error("status command does not match feature pin");
endmodule // nbl_host_properties
bind nbl_host nbl_host_properties chk_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata_q(rdata_q), .flash_cle(flash_cle), .flash_ale(flash_ale),
  .flash_we_n(flash_we_n), .output_strobe_n(output_strobe_n), .flash_ce_n(flash_ce_n),
  .flash_wp_n_q(flash_wp_n_q), .flash_io_out(flash_io_out), .flash_io_oe(flash_io_oe),
  .flash_io_in(flash_io_in), .flash_rb_n(flash_rb_n),
  .lock_feature_select(lock_feature_select));

/* nbl_host_tb_top.sv */
// self-checking bench for the block lock host controller
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_compared = n_compared + 1; if ((got) !== (ex)) begin \
  num_errors = num_errors + 1; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module nbl_host_tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] addr = 4'h0;
  reg [15:0] wdata = 16'h0000;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg lfs = 1'b1;
  reg hold_busy = 1'b0;
  wire [15:0] rdata_q;
  wire cle, ale, we_n, re_n, ce_n, wp_n, io_oe, rb_n;
  wire [7:0] io_out, io_in;
  reg [15:0] v;
  reg [2:0] r;
  integer num_errors = 0;
  integer n_compared = 0;
  always #20 clk = ~clk;
  nbl_host #(.RECOVERY_CYC(10)) dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_q(rdata_q), .flash_cle(cle), .flash_ale(ale), .flash_we_n(we_n),
    .output_strobe_n(re_n), .flash_ce_n(ce_n), .flash_wp_n_q(wp_n), .flash_io_out(io_out),
    .flash_io_oe(io_oe), .flash_io_in(io_in), .flash_rb_n(rb_n), .lock_feature_select(lfs));
  nbl_flash_model dev_u (.cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .ce_n(ce_n),
    .wp_n(wp_n), .io_out(io_out), .lfs(lfs), .hold_busy(hold_busy), .io_in(io_in), .rb_n(rb_n));
  // register port cycles, one strobe each
  task wr_reg(input [3:0] a, input [15:0] d); begin
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  end endtask
  task rd_reg(input [3:0] a); begin
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 v = rdata_q;
  end endtask
  // bounded poll of the idle flag; a hang counts as a mismatch
  task wait_idle; integer n; begin
    n = 0;
    rd_reg(4'h3);
    while (v[1] !== 1'b1 && n < 300) begin rd_reg(4'h3); n = n + 1; end
    `CHK("idle", 1'b1, v[1])
  end endtask
  task run(input [2:0] op, input [3:0] s, input [3:0] e); begin
    wr_reg(4'h1, {12'h000, s});
    wr_reg(4'h2, {12'h000, e});
    wr_reg(4'h0, {12'h000, 1'b1, op});
    repeat (2) @(posedge clk);
    wait_idle;
  end endtask
  task q(input [3:0] b); begin run(3'h3, b, b); rd_reg(4'h4); r = v[2:0]; end endtask
  task s_power; begin
    wait_idle; `CHK("feature", 1'b1, v[3])
    q(4'h0); `CHK("blk0", 3'h2, r)
    q(4'h9); `CHK("blk9", 3'h2, r)
  end endtask
  task s_unlock; begin
    run(3'h1, 4'h3, 4'h5);
    q(4'h2); `CHK("blk2", 3'h2, r)
    q(4'h3); `CHK("blk3", 3'h6, r)
    q(4'h5); `CHK("blk5", 3'h6, r)
    run(3'h1, 4'h7, 4'h7);
    q(4'h7); `CHK("blk7", 3'h6, r)
    q(4'h3); `CHK("blk3", 3'h2, r)
  end endtask
  task s_tight; begin
    run(3'h2, 4'h0, 4'h0);
    q(4'h7); `CHK("blk7", 3'h6, r)
    q(4'h0); `CHK("blk0", 3'h1, r)
    run(3'h1, 4'h0, 4'hF);
    q(4'h0); `CHK("blk0", 3'h1, r)
    run(3'h4, 4'h0, 4'h0);
    q(4'h0); `CHK("blk0", 3'h2, r)
    q(4'h7); `CHK("blk7", 3'h2, r)
  end endtask
  task s_lock; begin
    run(3'h1, 4'h2, 4'h4);
    run(3'h0, 4'h0, 4'h0);
    q(4'h3); `CHK("blk3", 3'h2, r)
  end endtask
  task s_refuse; begin
    run(3'h1, 4'h5, 4'h2);
    rd_reg(4'h3); `CHK("err", 1'b1, v[2])
    q(4'h5); `CHK("blk5", 3'h2, r)
    @(posedge clk);
    hold_busy <= 1'b1;
    run(3'h3, 4'h1, 4'h1);
    rd_reg(4'h3); `CHK("err", 1'b1, v[2])
    @(posedge clk);
    hold_busy <= 1'b0;
    rd_reg(4'hF); `CHK("unmapped", 16'h0000, v)
  end endtask
  task s_legacy; begin
    @(posedge clk);
    lfs <= 1'b0;
    repeat (4) @(posedge clk);
    run(3'h3, 4'h0, 4'h0);
    rd_reg(4'h4); `CHK("status", 8'hC0, v[7:0])
    @(posedge clk);
    lfs <= 1'b1;
  end endtask
  task wrap_up; begin
    $display("compares %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  end endtask
  initial begin
    #800000;
    num_errors = num_errors + 1;
    wrap_up;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    s_power;
    s_unlock;
    s_tight;
    s_lock;
    s_refuse;
    s_legacy;
    wrap_up;
  end
endmodule // nbl_host_tb_top

/* nbl_map.vh */
// command codes, register offsets and timing constants of the block lock controller
`ifndef NBL_MAP_VH
`define NBL_MAP_VH
`define NBL_CMD_LOCK 8'h2A
`define NBL_CMD_UNLOCK_START 8'h23
`define NBL_CMD_UNLOCK_END 8'h24
`define NBL_CMD_LOCK_TIGHT 8'h2C
`define NBL_CMD_LOCK_STATUS 8'h7A
`define NBL_CMD_STATUS 8'h70
`define NBL_OP_LOCK 3'h0
`define NBL_OP_UNLOCK 3'h1
`define NBL_OP_TIGHT 3'h2
`define NBL_OP_QUERY 3'h3
`define NBL_OP_WP_PULSE 3'h4
`define NBL_REG_CTRL 4'h0
`define NBL_REG_START 4'h1
`define NBL_REG_END 4'h2
`define NBL_REG_STATUS 4'h3
`define NBL_REG_RESULT 4'h4
`define NBL_CTRL_GO_BIT 3
`define NBL_STS_BUSY_BIT 0
`define NBL_STS_READY_BIT 1
`define NBL_STS_ERR_BIT 2
`define NBL_STS_LFS_BIT 3
`define NBL_STS_RB_BIT 4
`define NBL_RECOVERY_NS 10000
`define NBL_CLK_NS 40
`define NBL_RECOVERY_CYC ((`NBL_RECOVERY_NS + `NBL_CLK_NS - 1) / `NBL_CLK_NS)
`define NBL_SETUP_NS 100
`define NBL_SETUP_CYC ((`NBL_SETUP_NS + `NBL_CLK_NS - 1) / `NBL_CLK_NS)
`define NBL_WP_PULSE_NS 200
`define NBL_WP_PULSE_CYC ((`NBL_WP_PULSE_NS + `NBL_CLK_NS - 1) / `NBL_CLK_NS)
`define NBL_RESET_CTRL 8'h00
`endif
